// file: bench/bwt_core_sva.sv
// Port checker for the buffer-write / idle-timer block
`timescale 1ns/1ps
module bwt_core_sva (
  input wire logic clk,
  input wire logic rst,
  input wire logic [8:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest,
  input wire bwt_pkg::bwt_bufwr_s buf_wr,
  input wire logic spindle_turning,
  input wire logic spin_up_req,
  input wire logic standby_req,
  input wire logic idle_mode
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (rst);
  wait_one_a: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("access not answered after one wait cycle");
  wait_low_a: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low longer than one cycle");
  word_cause_a: assert property (buf_wr.we |-> $past(write && !waitrequest && address == bwt_pkg::IDX_DATA))
    else $error("buffer write without a data access");
  word_pulse_a: assert property (buf_wr.we |=> !buf_wr.we)
    else $error("buffer write strobe too long");
  spin_skip_a: assert property (spin_up_req |-> !spindle_turning)
    else $error("spin-up asked while spindle turns");
  spin_idle_a: assert property (spin_up_req |-> idle_mode)
    else $error("spin-up without idle mode");
  standby_exit_a: assert property (standby_req |-> idle_mode ##1 !idle_mode)
    else $error("standby entry not from idle mode");
  standby_pulse_a: assert property (standby_req |=> !standby_req)
    else $error("standby request too long");
endmodule : bwt_core_sva
bind bwt_core bwt_core_sva chk_u (.clk(clk), .rst(rst), .address(address), .read(read),
  .write(write), .waitrequest(waitrequest), .buf_wr(buf_wr), .spindle_turning(spindle_turning),
  .spin_up_req(spin_up_req), .standby_req(standby_req), .idle_mode(idle_mode));

// file: bench/bwt_core_tb.sv
// Self-checking bench for the buffer-write / idle-timer block
`timescale 1ns/1ps
module bwt_core_tb;
  localparam int DIV = 4;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic spindle_turning = 1'b1;
  logic [8:0] address;
  logic read, write, waitrequest, irq, spin_up_req, standby_req, idle_mode, hung;
  logic [31:0] writedata, readdata, q;
  logic [3:0] byteenable;
  bwt_pkg::bwt_bufwr_s buf_wr;
  int mismatches = 0;
  int tests_run = 0;
  int widx = 0;
  int spins = 0;
  logic [15:0] exp_q[$];
  always #4 clk = ~clk;
  bwt_core #(.TICK_DIV(DIV)) dut_u (.clk(clk), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .irq(irq), .buf_wr(buf_wr), .spindle_turning(spindle_turning),
    .spin_up_req(spin_up_req), .standby_req(standby_req), .idle_mode(idle_mode));
  bwt_host host_u (.clk(clk), .waitrequest(waitrequest), .readdata(readdata),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .hung(hung));
  task automatic print_verdict;
    if (mismatches == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_val
  task automatic check_word(input bwt_pkg::bwt_bufwr_s got);
    logic [15:0] w;
    tests_run++;
    w = (exp_q.size() > 0) ? exp_q.pop_front() : ~got.data;
    if (got.addr !== widx[7:0] || got.data !== w) begin
      mismatches++;
      $display("Error at %0t: buffer word %h at %h", $time, got.data, got.addr);
    end
    widx++;
  endtask : check_word
  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    host_u.xfer(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [8:0] a);
    host_u.xfer(1'b0, a, 32'h0, q);
  endtask : rd
  always @(posedge clk) begin
    if (buf_wr.we === 1'b1) check_word(buf_wr);
    if (spin_up_req === 1'b1) spins++;
    if (hung === 1'b1) begin
      mismatches++;
      print_verdict();
    end
  end
  initial begin
    int sc, n, e;
    logic [15:0] w;
    void'($urandom(32'h9d02));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    check_val({29'h0, waitrequest, irq, idle_mode}, 32'h4);
    rd(bwt_pkg::IDX_CMD);
    check_val(q, 32'h40);
    rd(9'h0aa);
    check_val(q, 32'h0);
    // Unknown opcode ends in the abort path with the error bit
    wr(bwt_pkg::IDX_CMD, 32'h0);
    rd(bwt_pkg::IDX_FEAT);
    check_val(q, {24'h0, bwt_pkg::FAULT_ABORT});
    rd(bwt_pkg::IDX_CMD);
    check_val(q, 32'h41);
    wr(bwt_pkg::IDX_IRQ_MASK, 32'h3);
    wr(bwt_pkg::IDX_CMD, {24'h0, bwt_pkg::OP_BUF_WRITE});
    rd(bwt_pkg::IDX_CMD);
    check_val(q, 32'h48);
    for (int i = 0; i < 256; i++) begin
      w = 16'($urandom);
      exp_q.push_back(w);
      wr(bwt_pkg::IDX_DATA, {16'h0, w});
    end
    // Extra word after the sector must be dropped
    wr(bwt_pkg::IDX_DATA, 32'h1234);
    rd(bwt_pkg::IDX_IRQ_STAT);
    check_val(q, 32'h1);
    check_val({31'h0, irq}, 32'h1);
    check_val(widx, 256);
    wr(bwt_pkg::IDX_IRQ_MASK, 32'h0);
    rd(bwt_pkg::IDX_CMD);
    check_val({31'h0, irq}, 32'h0);
    wr(bwt_pkg::IDX_IRQ_STAT, 32'h1);
    wr(bwt_pkg::IDX_IRQ_MASK, 32'h3);
    for (int k = 0; k < 2; k++) begin
      wr(bwt_pkg::IDX_SC, 32'h0);
      wr(bwt_pkg::IDX_CMD, {24'h0, k ? bwt_pkg::OP_IDLE_B : bwt_pkg::OP_IDLE_A});
      rd(bwt_pkg::IDX_POWER);
      check_val(q, 32'h1);
      rd(bwt_pkg::IDX_IRQ_STAT);
      check_val(q, 32'h1);
      wr(bwt_pkg::IDX_IRQ_STAT, 32'h1);
    end
    spindle_turning <= 1'b0;
    sc = 1 + int'($urandom % 4);
    e = sc * bwt_pkg::SEC_PER_STEP_SHORT * DIV;
    wr(bwt_pkg::IDX_SC, 32'(sc));
    wr(bwt_pkg::IDX_CMD, {24'h0, bwt_pkg::OP_IDLE_A});
    rd(bwt_pkg::IDX_POWER);
    check_val(q, 32'h7);
    wr(bwt_pkg::IDX_CMD, {24'h0, bwt_pkg::OP_IDLE_B});
    n = 0;
    while (standby_req !== 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    check_val({31'h0, n >= e - DIV - 2 && n <= e + DIV + 2}, 32'h1);
    rd(bwt_pkg::IDX_IRQ_STAT);
    check_val(q, 32'h3);
    check_val({31'h0, idle_mode}, 32'h0);
    check_val(spins, 2);
    print_verdict();
  end
endmodule : bwt_core_tb

// file: bench/bwt_host.sv
// Avalon-MM host model standing in for the task-file host adapter
`timescale 1ns/1ps
module bwt_host (
  input wire logic clk,
  input wire logic waitrequest,
  input wire logic [31:0] readdata,
  output logic [8:0] address,
  output logic read,
  output logic write,
  output logic [31:0] writedata,
  output logic [3:0] byteenable,
  output logic hung
);
  initial begin
    address = '0;
    read = 1'b0;
    write = 1'b0;
    writedata = '0;
    byteenable = '0;
    hung = 1'b0;
  end
  task automatic xfer(input logic we, input logic [8:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    @(posedge clk);
    address <= a;
    writedata <= d;
    byteenable <= 4'hf;
    write <= we;
    read <= !we;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest && n < 64);
    q = readdata;
    hung <= hung | waitrequest;
    write <= 1'b0;
    read <= 1'b0;
    // Released lines show a changed value, not the last one
    address <= ~a;
    writedata <= ~d;
    byteenable <= 4'h0;
  endtask : xfer
endmodule : bwt_host

// file: include/bwt_pkg.sv
// Shared constants, types and period table for the buffer-write / idle-timer block
package bwt_pkg;
  // Register indices; byte address is four times the index
  localparam logic [8:0] IDX_DATA = 9'h1f0;
  localparam logic [8:0] IDX_FEAT = 9'h1f1;
  localparam logic [8:0] IDX_SC = 9'h1f2;
  localparam logic [8:0] IDX_SN = 9'h1f3;
  localparam logic [8:0] IDX_CL = 9'h1f4;
  localparam logic [8:0] IDX_CH = 9'h1f5;
  localparam logic [8:0] IDX_DH = 9'h1f6;
  localparam logic [8:0] IDX_CMD = 9'h1f7;
  localparam logic [8:0] IDX_IRQ_STAT = 9'h100;
  localparam logic [8:0] IDX_IRQ_MASK = 9'h101;
  localparam logic [8:0] IDX_POWER = 9'h102;

  // Opcodes
  localparam logic [7:0] OP_BUF_WRITE = 8'he8;
  localparam logic [7:0] OP_IDLE_A = 8'h97;
  localparam logic [7:0] OP_IDLE_B = 8'he3;

  // Condition flag bits
  localparam int ST_BUSY = 7;
  localparam int ST_READY = 6;
  localparam int ST_DRQ = 3;
  localparam int ST_ERR = 0;
  localparam logic [7:0] FAULT_ABORT = 8'h04;

  // Interrupt status bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_STANDBY = 1;
  localparam int IRQ_W = 2;

  // Power register bits
  localparam int PWR_IDLE = 0;
  localparam int PWR_APD_EN = 1;
  localparam int PWR_RUN = 2;

  // Sector buffer: 512 bytes as 256 16-bit words
  localparam int BUF_WORDS = 256;
  localparam logic [7:0] BUF_LAST = 8'hff;

  // Timer periods in seconds and the sector count codes that select them
  localparam int SEC_PER_STEP_SHORT = 5;
  localparam int SEC_PER_STEP_LONG = 1800;
  localparam int SEC_21MIN = 1260;
  localparam int SEC_8H = 28800;
  localparam int SEC_21MIN15S = 1275;
  localparam logic [7:0] SC_SHORT_MAX = 8'hf0;
  localparam logic [7:0] SC_LONG_MAX = 8'hfb;
  localparam logic [7:0] SC_21MIN = 8'hfc;
  localparam logic [7:0] SC_8H = 8'hfd;

  // Clock and tick rate
  localparam int CLK_HZ = 125000000;
  localparam int TICK_S = 1;

  typedef logic [15:0] bwt_secs_t;

  typedef enum logic [2:0] {
    BWT_READY = 3'b000,
    BWT_PREP = 3'b001,
    BWT_XFER = 3'b011,
    BWT_IDLECMD = 3'b010,
    BWT_ABORT = 3'b110
  } bwt_state_e;

  typedef struct packed {
    logic [7:0] feature_input;
    logic [7:0] sector_count;
    logic [7:0] sector_number;
    logic [7:0] cylinder_low;
    logic [7:0] cylinder_high;
    logic [7:0] drive_head;
  } bwt_taskfile_s;

  typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic [15:0] data;
  } bwt_bufwr_s;

  function automatic bwt_secs_t bwt_period(input logic [7:0] sc);
    int secs;
    secs = 0;
    if (sc == 8'h00) secs = 0;
    else if (sc <= SC_SHORT_MAX) secs = int'(sc) * SEC_PER_STEP_SHORT;
    else if (sc <= SC_LONG_MAX) secs = (int'(sc) - int'(SC_SHORT_MAX)) * SEC_PER_STEP_LONG;
    else if (sc == SC_21MIN) secs = SEC_21MIN;
    else if (sc == SC_8H) secs = SEC_8H;
    else secs = SEC_21MIN15S;
    return secs[15:0];
  endfunction : bwt_period
endpackage : bwt_pkg

// file: src/bwt_core.sv
// Buffer overwrite and idle command handling with automatic power-down timer
`timescale 1ns/1ps
// Overview of operation
// - Opcode E8 sets busy and prepares the buffer for host data.
// - When ready, raise transfer request and drop busy.
// - Host sends exactly 512 bytes; stored, interrupt after the last.
// - Idle opcodes set busy, enter idle, clear busy, interrupt.
// - Idle completion interrupt does not wait for idle entry to finish.
// - Spindle already turning means no spin-up request.
// - Nonzero sector count enables power-down and starts countdown at once.
// - Countdown expiry without commands puts the drive into standby.
// - Zero sector count disables the power-down timer.
// - Command during countdown reloads the full period, then executes.
// - Countdown restarts once the interrupting command finishes.
// - Period table from sector count: x5 s, x30 min, fixed codes.
module bwt_core #(
  parameter int TICK_DIV = bwt_pkg::CLK_HZ * bwt_pkg::TICK_S
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [8:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic irq,
  output bwt_pkg::bwt_bufwr_s buf_wr,
  input wire logic spindle_turning,
  output logic spin_up_req,
  output logic standby_req,
  output logic idle_mode
);
  // Bus handshake: one wait cycle, access takes effect when waitrequest is low
  logic next_waitrequest;
  logic [31:0] next_readdata;
  logic acc;
  logic wr_acc;

  always_comb begin
    next_waitrequest = ~((read | write) & waitrequest);
  end

  assign acc = (read | write) & ~waitrequest;
  assign wr_acc = write & ~waitrequest & byteenable[0];

  // Spindle input filter
  logic spin_s1, spin_s2, spin_s3, spin_f;
  logic next_spin_f;

  always_comb begin
    next_spin_f = (spin_s2 == spin_s3) ? spin_s3 : spin_f;
  end

  // Task file and command state
  bwt_pkg::bwt_taskfile_s tf, next_tf;
  bwt_pkg::bwt_state_e state, next_state;
  logic [7:0] flags, next_flags;
  logic [7:0] fault_code, next_fault_code;
  logic [7:0] word_idx, next_word_idx;
  bwt_pkg::bwt_bufwr_s next_buf_wr;
  logic next_idle_mode;
  logic next_spin_up_req;
  logic done_ev;
  logic cmd_wr;
  logic data_wr;

  assign cmd_wr = wr_acc && address == bwt_pkg::IDX_CMD && state == bwt_pkg::BWT_READY;
  assign data_wr = write && !waitrequest && address == bwt_pkg::IDX_DATA
                   && byteenable[1:0] == 2'b11 && state == bwt_pkg::BWT_XFER;

  always_comb begin
    next_tf = tf;
    next_state = state;
    next_flags = flags;
    next_fault_code = fault_code;
    next_word_idx = word_idx;
    next_buf_wr = '0;
    next_idle_mode = idle_mode;
    next_spin_up_req = 1'b0;
    done_ev = 1'b0;
    if (wr_acc && state == bwt_pkg::BWT_READY) begin
      case (address)
        bwt_pkg::IDX_FEAT: next_tf.feature_input = writedata[7:0];
        bwt_pkg::IDX_SC: next_tf.sector_count = writedata[7:0];
        bwt_pkg::IDX_SN: next_tf.sector_number = writedata[7:0];
        bwt_pkg::IDX_CL: next_tf.cylinder_low = writedata[7:0];
        bwt_pkg::IDX_CH: next_tf.cylinder_high = writedata[7:0];
        bwt_pkg::IDX_DH: next_tf.drive_head = writedata[7:0];
        default: ;
      endcase
    end
    case (state)
      bwt_pkg::BWT_READY: begin
        if (cmd_wr) begin
          next_flags[bwt_pkg::ST_BUSY] = 1'b1;
          next_flags[bwt_pkg::ST_ERR] = 1'b0;
          next_fault_code = '0;
          case (writedata[7:0])
            bwt_pkg::OP_BUF_WRITE: next_state = bwt_pkg::BWT_PREP;
            bwt_pkg::OP_IDLE_A, bwt_pkg::OP_IDLE_B: next_state = bwt_pkg::BWT_IDLECMD;
            default: next_state = bwt_pkg::BWT_ABORT;
          endcase
        end
      end
      bwt_pkg::BWT_PREP: begin
        next_word_idx = '0;
        next_flags[bwt_pkg::ST_DRQ] = 1'b1;
        next_flags[bwt_pkg::ST_BUSY] = 1'b0;
        next_state = bwt_pkg::BWT_XFER;
      end
      bwt_pkg::BWT_XFER: begin
        if (data_wr) begin
          next_buf_wr.we = 1'b1;
          next_buf_wr.addr = word_idx;
          next_buf_wr.data = writedata[15:0];
          next_word_idx = word_idx + 8'h01;
          if (word_idx == bwt_pkg::BUF_LAST) begin
            next_flags[bwt_pkg::ST_DRQ] = 1'b0;
            done_ev = 1'b1;
            next_state = bwt_pkg::BWT_READY;
          end
        end
      end
      bwt_pkg::BWT_IDLECMD: begin
        next_idle_mode = 1'b1;
        next_spin_up_req = ~spin_f;
        next_flags[bwt_pkg::ST_BUSY] = 1'b0;
        done_ev = 1'b1;
        next_state = bwt_pkg::BWT_READY;
      end
      bwt_pkg::BWT_ABORT: begin
        next_flags[bwt_pkg::ST_BUSY] = 1'b0;
        next_flags[bwt_pkg::ST_ERR] = 1'b1;
        next_fault_code = bwt_pkg::FAULT_ABORT;
        done_ev = 1'b1;
        next_state = bwt_pkg::BWT_READY;
      end
      default: begin
        next_state = bwt_pkg::BWT_READY;
        next_flags = '0;
      end
    endcase
    if (standby_req) next_idle_mode = 1'b0;
  end

  // Power-down timer
  logic [31:0] presc, next_presc;
  logic tick;
  logic apd_en, next_apd_en;
  logic run, next_run;
  bwt_pkg::bwt_secs_t period, next_period;
  bwt_pkg::bwt_secs_t remain, next_remain;
  logic next_standby_req;
  logic idle_cmd;

  assign idle_cmd = state == bwt_pkg::BWT_IDLECMD;

  always_comb begin
    next_presc = presc + 32'h1;
    tick = 1'b0;
    if (presc == 32'(TICK_DIV - 1)) begin
      next_presc = '0;
      tick = 1'b1;
    end
    next_apd_en = apd_en;
    next_run = run;
    next_period = period;
    next_remain = remain;
    next_standby_req = 1'b0;
    if (cmd_wr) begin
      next_remain = period;
      next_run = 1'b0;
    end else if (idle_cmd) begin
      next_period = bwt_pkg::bwt_period(tf.sector_count);
      next_remain = bwt_pkg::bwt_period(tf.sector_count);
      next_apd_en = tf.sector_count != 8'h00;
      next_run = tf.sector_count != 8'h00;
      next_presc = '0;
    end else if (done_ev && idle_mode && apd_en) begin
      next_remain = period;
      next_run = 1'b1;
      next_presc = '0;
    end else if (run && tick && state == bwt_pkg::BWT_READY) begin
      next_remain = remain - 16'h1;
      if (remain == 16'h1) begin
        next_run = 1'b0;
        next_standby_req = 1'b1;
      end
    end
  end

  // Interrupt status, sticky, write one to clear; a set in the same cycle wins
  logic [bwt_pkg::IRQ_W-1:0] irq_stat, next_irq_stat;
  logic [bwt_pkg::IRQ_W-1:0] irq_mask, next_irq_mask;
  logic next_irq;

  always_comb begin
    next_irq_stat = irq_stat;
    next_irq_mask = irq_mask;
    if (wr_acc && address == bwt_pkg::IDX_IRQ_STAT)
      next_irq_stat = irq_stat & ~writedata[bwt_pkg::IRQ_W-1:0];
    if (wr_acc && address == bwt_pkg::IDX_IRQ_MASK)
      next_irq_mask = writedata[bwt_pkg::IRQ_W-1:0];
    if (done_ev) next_irq_stat[bwt_pkg::IRQ_DONE] = 1'b1;
    if (next_standby_req) next_irq_stat[bwt_pkg::IRQ_STANDBY] = 1'b1;
    next_irq = |(next_irq_stat & next_irq_mask);
  end

  // Read mux, captured during the wait cycle
  always_comb begin
    next_readdata = '0;
    if (read && waitrequest) begin
      case (address)
        bwt_pkg::IDX_FEAT: next_readdata[7:0] = fault_code;
        bwt_pkg::IDX_SC: next_readdata[7:0] = tf.sector_count;
        bwt_pkg::IDX_SN: next_readdata[7:0] = tf.sector_number;
        bwt_pkg::IDX_CL: next_readdata[7:0] = tf.cylinder_low;
        bwt_pkg::IDX_CH: next_readdata[7:0] = tf.cylinder_high;
        bwt_pkg::IDX_DH: next_readdata[7:0] = tf.drive_head;
        bwt_pkg::IDX_CMD: next_readdata[7:0] = flags | (8'h01 << bwt_pkg::ST_READY);
        bwt_pkg::IDX_IRQ_STAT: next_readdata[bwt_pkg::IRQ_W-1:0] = irq_stat;
        bwt_pkg::IDX_IRQ_MASK: next_readdata[bwt_pkg::IRQ_W-1:0] = irq_mask;
        bwt_pkg::IDX_POWER: begin
          next_readdata[bwt_pkg::PWR_IDLE] = idle_mode;
          next_readdata[bwt_pkg::PWR_APD_EN] = apd_en;
          next_readdata[bwt_pkg::PWR_RUN] = run;
        end
        default: next_readdata = '0;
      endcase
    end else begin
      next_readdata = readdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      waitrequest <= 1'b1;
      readdata <= '0;
      spin_s1 <= 1'b0;
      spin_s2 <= 1'b0;
      spin_s3 <= 1'b0;
      spin_f <= 1'b0;
      tf <= '0;
      state <= bwt_pkg::BWT_READY;
      flags <= '0;
      fault_code <= '0;
      word_idx <= '0;
      buf_wr <= '0;
      idle_mode <= 1'b0;
      spin_up_req <= 1'b0;
      presc <= '0;
      apd_en <= 1'b0;
      run <= 1'b0;
      period <= '0;
      remain <= '0;
      standby_req <= 1'b0;
      irq_stat <= '0;
      irq_mask <= '0;
      irq <= 1'b0;
    end else begin
      waitrequest <= next_waitrequest;
      readdata <= next_readdata;
      spin_s1 <= spindle_turning;
      spin_s2 <= spin_s1;
      spin_s3 <= spin_s2;
      spin_f <= next_spin_f;
      tf <= next_tf;
      state <= next_state;
      flags <= next_flags;
      fault_code <= next_fault_code;
      word_idx <= next_word_idx;
      buf_wr <= next_buf_wr;
      idle_mode <= next_idle_mode;
      spin_up_req <= next_spin_up_req;
      presc <= next_presc;
      apd_en <= next_apd_en;
      run <= next_run;
      period <= next_period;
      remain <= next_remain;
      standby_req <= next_standby_req;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      irq <= next_irq;
    end
  end
endmodule : bwt_core
